// ==== rtl/mau_addr_unit.sv ====
`timescale 1ns/1ps
`include "mau_params.svh"

// Summary of operation
// - word low byte goes to the lower address, high byte to the next
// - words at any alignment run as two successive byte bus cycles
// - first fetch after reset comes from physical address FFFF0H
// - interrupt pointers come from a 256-entry table below 00400H
// - static strap picks own bus controls (high) or coded status (low)
// - instruction fetches other than the startup fetch use the code segment, never overridden
// - stack accesses use the stack segment; frame-base references use it unless an override is given
// - data references use the data segment unless an override is given
// - string destinations use the extra segment
// - minimum mode drives transceiver enable, direction and address latch strobe
// - maximum mode emits cycle type on three status outputs for a bus controller
// - maximum mode provides lock, queue status and two request/grant lines
// - physical address is 20 bits over one linear megabyte
// - segments span 64K bytes and start on 16-byte boundaries
module mau_addr_unit
  import mau_pkg::*;
#(
  parameter int PHYS_W = `MAU_PHYS_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic configModeStrap,
  input wire logic [15:0] codeSegment,
  input wire logic [15:0] stackSegment,
  input wire logic [15:0] dataSegment,
  input wire logic [15:0] extraSegment,
  input wire logic reqValid,
  output logic reqReady,
  input wire mau_ref_e reqKind,
  input wire logic reqWord,
  input wire logic reqWrite,
  input wire logic [15:0] reqOffset,
  input wire logic [15:0] reqWriteData,
  input wire logic [7:0] reqIntType,
  input wire logic reqOverride,
  input wire mau_seg_e reqOverrideSeg,
  output logic respValid,
  output logic [15:0] respData,
  output logic [15:0] respSegment,
  output logic [PHYS_W-1:0] busAddr,
  output logic [7:0] busDataOut,
  output logic busDataOe,
  input wire logic [7:0] busDataIn,
  input wire logic busReady,
  output logic addrLatchStrobe,
  output logic readStrobe,
  output logic writeStrobe,
  output logic transceiverEnableOut,
  output logic transferDirectionOut,
  output logic cycleStatusBitZero,
  output logic cycleStatusBitOne,
  output logic cycleStatusBitTwo,
  input wire logic lockRequest,
  output logic busLockOut,
  input wire logic [1:0] queueStatusIn,
  output logic [1:0] queueStatusOut,
  input wire logic [1:0] requestGrantLineIn,
  output logic [1:0] requestGrantLineOut,
  output logic [1:0] requestGrantLineOe
);
  if (PHYS_W != 20) begin : g_check
    $error("mau_addr_unit supports only a 20-bit physical address");
  end

  mau_bus_e st_r, st_nxt;
  mau_ref_e kind_r, kind_nxt;
  logic [15:0] seg_r, seg_nxt;
  logic [15:0] off_r, off_nxt;
  logic wr_r, wr_nxt;
  logic [15:0] wdata_r, wdata_nxt;
  logic [2:0] total_r, total_nxt;
  logic [1:0] idx_r, idx_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic boot_r, boot_nxt;
  logic [7:0] dout_r, dout_nxt;
  logic doe_r, doe_nxt;
  logic rv_r, rv_nxt;
  logic [15:0] rd_r, rd_nxt;
  logic [15:0] rs_r, rs_nxt;
  logic maxMode_r, maxMode_nxt;
  logic lock_r, lock_nxt;
  logic [1:0] qs_r, qs_nxt;
  mau_rg_e rg_r, rg_nxt;
  logic rgLine_r, rgLine_nxt;
  logic [1:0] pend_r, pend_nxt;
  logic [15:0] selSeg;
  logic [15:0] byteOff;
  logic [2:0] stat;
  logic accept;

  // segment choice per reference kind
  always_comb begin
    selSeg = dataSegment;
    unique case (reqKind)
      MAU_REF_FETCH: selSeg = codeSegment;
      MAU_REF_STACK: selSeg = stackSegment;
      MAU_REF_FRAME: selSeg = stackSegment;
      MAU_REF_DATA: selSeg = dataSegment;
      MAU_REF_STRDST: selSeg = extraSegment;
      MAU_REF_VECTOR: selSeg = `MAU_VECTOR_SEG;
      default: selSeg = dataSegment;
    endcase
    // push/pop, fetch, string destination and vector reads ignore overrides
    if (reqOverride && (reqKind == MAU_REF_DATA || reqKind == MAU_REF_FRAME)) begin
      unique case (reqOverrideSeg)
        MAU_SEG_CODE: selSeg = codeSegment;
        MAU_SEG_STACK: selSeg = stackSegment;
        MAU_SEG_DATA: selSeg = dataSegment;
        MAU_SEG_EXTRA: selSeg = extraSegment;
      endcase
    end
  end

  // offset wraps inside the 64K segment for the second byte of a word
  assign byteOff = off_r + {14'h0000, idx_r};

  mau_phys_addr #(.PHYS_W(PHYS_W)) u_addr (
    .segment(seg_r),
    .offset(byteOff),
    .physAddr(busAddr)
  );

  // requests wait while a grant is out or the startup fetch is pending
  assign reqReady = (st_r == MAU_T_IDLE) && !boot_r && (rg_r == MAU_RG_IDLE);
  assign accept = reqValid && reqReady;

  always_comb begin
    st_nxt = st_r;
    kind_nxt = kind_r;
    seg_nxt = seg_r;
    off_nxt = off_r;
    wr_nxt = wr_r;
    wdata_nxt = wdata_r;
    total_nxt = total_r;
    idx_nxt = idx_r;
    rdata_nxt = rdata_r;
    boot_nxt = boot_r;
    dout_nxt = dout_r;
    doe_nxt = doe_r;
    rv_nxt = 1'b0;
    rd_nxt = rd_r;
    rs_nxt = rs_r;
    unique case (st_r)
      MAU_T_IDLE: begin
        if (boot_r && rg_r == MAU_RG_IDLE) begin
          st_nxt = MAU_T_T1;
          kind_nxt = MAU_REF_FETCH;
          seg_nxt = `MAU_RESET_SEG;
          off_nxt = `MAU_RESET_OFF;
          wr_nxt = 1'b0;
          total_nxt = `MAU_BYTES_BYTE;
          idx_nxt = 2'h0;
          rdata_nxt = 32'h0000_0000;
          boot_nxt = 1'b0;
        end else if (accept) begin
          st_nxt = MAU_T_T1;
          kind_nxt = reqKind;
          seg_nxt = selSeg;
          idx_nxt = 2'h0;
          rdata_nxt = 32'h0000_0000;
          wdata_nxt = reqWriteData;
          if (reqKind == MAU_REF_VECTOR) begin
            off_nxt = {6'h00, reqIntType, 2'h0};
            wr_nxt = 1'b0;
            total_nxt = `MAU_BYTES_VECTOR;
          end else begin
            off_nxt = reqOffset;
            wr_nxt = reqWrite && (reqKind != MAU_REF_FETCH);
            total_nxt = reqWord ? `MAU_BYTES_WORD : `MAU_BYTES_BYTE;
          end
        end
      end
      MAU_T_T1: begin
        st_nxt = MAU_T_T2;
        dout_nxt = idx_r[0] ? wdata_r[15:8] : wdata_r[7:0];
        doe_nxt = wr_r;
      end
      MAU_T_T2: st_nxt = MAU_T_T3;
      MAU_T_T3: begin
        if (busReady) begin
          st_nxt = MAU_T_T4;
          if (!wr_r) begin
            rdata_nxt[{idx_r, 3'b000} +: 8] = busDataIn;
          end
        end
      end
      MAU_T_T4: begin
        doe_nxt = 1'b0;
        if ({1'b0, idx_r} + 3'h1 == total_r) begin
          st_nxt = MAU_T_IDLE;
          rv_nxt = 1'b1;
          rd_nxt = rdata_r[15:0];
          rs_nxt = rdata_r[31:16];
        end else begin
          st_nxt = MAU_T_T1;
          idx_nxt = idx_r + 2'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= MAU_T_IDLE;
      kind_r <= MAU_REF_FETCH;
      seg_r <= 16'h0000;
      off_r <= 16'h0000;
      wr_r <= 1'b0;
      wdata_r <= 16'h0000;
      total_r <= 3'h0;
      idx_r <= 2'h0;
      rdata_r <= 32'h0000_0000;
      boot_r <= 1'b1;
      dout_r <= 8'h00;
      doe_r <= 1'b0;
      rv_r <= 1'b0;
      rd_r <= 16'h0000;
      rs_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      kind_r <= kind_nxt;
      seg_r <= seg_nxt;
      off_r <= off_nxt;
      wr_r <= wr_nxt;
      wdata_r <= wdata_nxt;
      total_r <= total_nxt;
      idx_r <= idx_nxt;
      rdata_r <= rdata_nxt;
      boot_r <= boot_nxt;
      dout_r <= dout_nxt;
      doe_r <= doe_nxt;
      rv_r <= rv_nxt;
      rd_r <= rd_nxt;
      rs_r <= rs_nxt;
    end
  end

  assign busDataOut = dout_r;
  assign busDataOe = doe_r;
  assign respValid = rv_r;
  assign respData = rd_r;
  assign respSegment = rs_r;

  // minimum mode: the unit makes its own strobes and buffer controls
  assign addrLatchStrobe = !maxMode_r && (st_r == MAU_T_T1);
  assign readStrobe = !maxMode_r && !wr_r && (st_r == MAU_T_T2 || st_r == MAU_T_T3);
  assign writeStrobe = !maxMode_r && wr_r && (st_r == MAU_T_T2 || st_r == MAU_T_T3);
  assign transceiverEnableOut = !maxMode_r && (st_r == MAU_T_T2 || st_r == MAU_T_T3);
  assign transferDirectionOut = !maxMode_r && wr_r && (st_r != MAU_T_IDLE);

  // maximum mode: coded cycle type, passive in T4 and idle
  always_comb begin
    stat = `MAU_STAT_PASSIVE;
    if (maxMode_r && (st_r == MAU_T_T1 || st_r == MAU_T_T2 || st_r == MAU_T_T3)) begin
      if (wr_r) begin
        stat = `MAU_STAT_WRITE;
      end else if (kind_r == MAU_REF_FETCH) begin
        stat = `MAU_STAT_FETCH;
      end else begin
        stat = `MAU_STAT_READ;
      end
    end
  end
  assign cycleStatusBitZero = stat[0];
  assign cycleStatusBitOne = stat[1];
  assign cycleStatusBitTwo = stat[2];

  // strap is static, so a plain registered copy is enough; reset reads as minimum mode
  always_comb begin
    maxMode_nxt = !configModeStrap;
    lock_nxt = maxMode_r && lockRequest;
    qs_nxt = maxMode_r ? queueStatusIn : 2'h0;
    // a new request pulse wins over the clear of its pending bit
    pend_nxt = pend_r;
    rg_nxt = rg_r;
    rgLine_nxt = rgLine_r;
    unique case (rg_r)
      MAU_RG_IDLE: begin
        // requests under lock are held and served once the lock drops
        if (maxMode_r && !lock_r && st_r == MAU_T_IDLE && pend_r != 2'h0) begin
          rg_nxt = MAU_RG_GRANT;
          rgLine_nxt = !pend_r[0];
          pend_nxt[!pend_r[0]] = 1'b0;
        end
      end
      MAU_RG_GRANT: rg_nxt = MAU_RG_HELD;
      MAU_RG_HELD: begin
        if (requestGrantLineIn[rgLine_r]) begin
          rg_nxt = MAU_RG_IDLE;
        end
      end
    endcase
    if (maxMode_r) begin
      for (int i = 0; i < 2; i++) begin
        if (requestGrantLineIn[i] && !(rg_r == MAU_RG_HELD && rgLine_r == i[0])) begin
          pend_nxt[i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      maxMode_r <= 1'b0;
      lock_r <= 1'b0;
      qs_r <= 2'h0;
      pend_r <= 2'h0;
      rg_r <= MAU_RG_IDLE;
      rgLine_r <= 1'b0;
    end else begin
      maxMode_r <= maxMode_nxt;
      lock_r <= lock_nxt;
      qs_r <= qs_nxt;
      pend_r <= pend_nxt;
      rg_r <= rg_nxt;
      rgLine_r <= rgLine_nxt;
    end
  end

  assign busLockOut = lock_r;
  assign queueStatusOut = qs_r;
  assign requestGrantLineOut = (rg_r == MAU_RG_GRANT) ? (rgLine_r ? 2'h2 : 2'h1) : 2'h0;
  assign requestGrantLineOe = requestGrantLineOut;
endmodule

// ==== rtl/mau_params.svh ====
`ifndef MAU_PARAMS_SVH
`define MAU_PARAMS_SVH

`define MAU_PHYS_W 20
`define MAU_RESET_SEG 16'hFFFF
`define MAU_RESET_OFF 16'h0000
`define MAU_RESET_VECTOR 20'hF_FFF0
`define MAU_STARTUP_TOP 20'hF_FFFF
`define MAU_VECTOR_TOP 20'h0_03FF
`define MAU_VECTOR_SEG 16'h0000
`define MAU_VECTOR_COUNT 256
`define MAU_BYTES_BYTE 3'h1
`define MAU_BYTES_WORD 3'h2
`define MAU_BYTES_VECTOR 3'h4
`define MAU_STAT_FETCH 3'h4
`define MAU_STAT_READ 3'h5
`define MAU_STAT_WRITE 3'h6
`define MAU_STAT_PASSIVE 3'h7

`endif

// ==== rtl/mau_phys_addr.sv ====
`timescale 1ns/1ps
`include "mau_params.svh"

module mau_phys_addr
  import mau_pkg::*;
#(
  parameter int PHYS_W = `MAU_PHYS_W
) (
  input wire logic [15:0] segment,
  input wire logic [15:0] offset,
  output logic [PHYS_W-1:0] physAddr
);
  if (PHYS_W != 20) begin : g_check
    $error("mau_phys_addr supports only a 20-bit physical address");
  end

  // carry out of bit 19 is dropped, so addresses wrap at the top of the megabyte
  assign physAddr = {segment, 4'h0} + {4'h0, offset};
endmodule

// ==== rtl/mau_pkg.sv ====
package mau_pkg;
  typedef enum logic [2:0] {
    MAU_REF_FETCH,
    MAU_REF_STACK,
    MAU_REF_FRAME,
    MAU_REF_DATA,
    MAU_REF_STRDST,
    MAU_REF_VECTOR
  } mau_ref_e;

  typedef enum logic [1:0] {
    MAU_SEG_CODE,
    MAU_SEG_STACK,
    MAU_SEG_DATA,
    MAU_SEG_EXTRA
  } mau_seg_e;

  typedef enum {MAU_T_IDLE, MAU_T_T1, MAU_T_T2, MAU_T_T3, MAU_T_T4} mau_bus_e;

  typedef enum {MAU_RG_IDLE, MAU_RG_GRANT, MAU_RG_HELD} mau_rg_e;
endpackage

// ==== tb/mau_addr_unit_assertions.sv ====
`timescale 1ns/1ps
module mau_addr_unit_assertions #(
  parameter int PHYS_W = 20
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic configModeStrap,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic reqWord,
  input wire logic respValid,
  input wire logic [PHYS_W-1:0] busAddr,
  input wire logic addrLatchStrobe,
  input wire logic readStrobe,
  input wire logic writeStrobe,
  input wire logic transceiverEnableOut,
  input wire logic transferDirectionOut,
  input wire logic busDataOe,
  input wire logic lockRequest,
  input wire logic busLockOut,
  input wire logic [1:0] queueStatusIn,
  input wire logic [1:0] queueStatusOut,
  input wire logic [1:0] requestGrantLineOut
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire logic take = reqValid && reqReady;
  wire logic quiet = !addrLatchStrobe && !readStrobe && !writeStrobe && !transceiverEnableOut;
  chk_boot_fetch: assert property ($fell(rst) |-> ##[1:4] busAddr == 20'hF_FFF0)
    else $error("boot address");
  chk_word_split: assert property (take && reqWord |=> !respValid [*8])
    else $error("word too short");
  chk_resp_bound: assert property (take |-> ##[5:400] respValid)
    else $error("no answer");
  chk_read_ctrl: assert property (readStrobe |-> transceiverEnableOut && !transferDirectionOut)
    else $error("read controls");
  chk_write_ctrl: assert property (writeStrobe |-> transceiverEnableOut && busDataOe
    && transferDirectionOut) else $error("write controls");
  chk_ale_cmd: assert property (addrLatchStrobe |=> readStrobe || writeStrobe)
    else $error("no command after latch");
  // strobes come from the registered strap copy, so two quiet cycles are needed
  chk_max_quiet: assert property (!configModeStrap && !$past(configModeStrap)
    && !$past(configModeStrap, 2) && !$past(rst, 2) |-> quiet) else $error("max mode strobe");
  chk_queue_pass: assert property (!$past(configModeStrap) && !$past(rst)
    |=> queueStatusOut == $past(queueStatusIn)) else $error("queue status");
  chk_lock_pass: assert property (!$past(configModeStrap) && !$past(rst)
    |=> busLockOut == $past(lockRequest)) else $error("lock");
  chk_grant_pulse: assert property (requestGrantLineOut != 2'h0 |-> !busLockOut
    ##1 requestGrantLineOut == 2'h0) else $error("grant");
  cover property (take && reqWord);
  cover property (respValid && !configModeStrap);
  cover property (requestGrantLineOut != 2'h0);
endmodule

bind mau_addr_unit mau_addr_unit_assertions #(.PHYS_W(PHYS_W)) chk_u (.*);

// ==== tb/mau_mem_model.sv ====
`timescale 1ns/1ps
module mau_mem_model (
  input wire logic clock,
  input wire logic slow,
  input wire logic [19:0] busAddr,
  input wire logic readStrobe,
  input wire logic writeStrobe,
  input wire logic busDataOe,
  input wire logic [7:0] busDataOut,
  input wire logic cycleStatusBitZero,
  input wire logic cycleStatusBitOne,
  input wire logic cycleStatusBitTwo,
  output logic [7:0] busDataIn,
  output logic busReady
);
  logic [7:0] mem [int];
  logic tick = 1'b0;
  wire logic [2:0] code = {cycleStatusBitTwo, cycleStatusBitOne, cycleStatusBitZero};
  wire logic rd = readStrobe || code == 3'h4 || code == 3'h5;
  wire logic wr = writeStrobe || code == 3'h6;
  initial busDataIn = 8'h00;
  initial busReady = 1'b1;
  // slow stalls every other cycle, so a wait state can only hit the first byte of a word
  always @(posedge clock) begin
    tick <= ~tick;
    busReady <= !slow || tick;
    if (wr && busDataOe) mem[busAddr] = busDataOut;
    // released lines flip each cycle so a stale byte never passes
    busDataIn <= !rd ? ~busDataIn : mem.exists(busAddr) ? mem[busAddr]
      : busAddr[7:0] ^ busAddr[19:12];
  end
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import mau_pkg::*;
  logic clock, rst, configModeStrap, reqValid, reqWord, reqWrite, reqOverride, busReady;
  logic lockRequest, slow, reqReady, respValid, busDataOe, addrLatchStrobe, readStrobe;
  logic writeStrobe, transceiverEnableOut, transferDirectionOut, busLockOut;
  logic cycleStatusBitZero, cycleStatusBitOne, cycleStatusBitTwo;
  logic [15:0] codeSegment, stackSegment, dataSegment, extraSegment;
  logic [15:0] reqOffset, reqWriteData, respData, respSegment;
  logic [19:0] busAddr;
  logic [7:0] reqIntType, busDataOut, busDataIn;
  logic [1:0] queueStatusIn, queueStatusOut, requestGrantLineIn, requestGrantLineOut;
  logic [1:0] requestGrantLineOe;
  mau_ref_e reqKind;
  mau_seg_e reqOverrideSeg;
  int failures = 0, comparisons = 0, cycles = 0;
  logic [7:0] bm [int];
  logic [19:0] addrQ [$];
  logic busyLast = 1'b0;
  logic [7:0] cycles_vt [3] = '{8'h00, 8'hFF, 8'h05};
  wire logic busy = readStrobe | writeStrobe | ~&{cycleStatusBitTwo, cycleStatusBitOne,
    cycleStatusBitZero};
  mau_addr_unit dut_u (.*);
  mau_mem_model mem_u (.*);

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic print_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  // each bus cycle start is logged with its address
  always @(posedge clock) begin
    cycles <= cycles + 1;
    busyLast <= busy;
    if (busy && !busyLast)
      addrQ.push_back(busAddr);
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic wait_ready();
    for (int t = 0; t < 300 && reqReady !== 1'b1; t++)
      @(negedge clock);
  endtask

  task automatic access(input mau_ref_e k, input logic w, input logic wr, input logic [15:0] off);
    logic [15:0] segs [4];
    logic [15:0] seg;
    logic [19:0] ea [4];
    logic [31:0] exp;
    logic doWr;
    logic [15:0] bo;
    int n;
    segs = '{codeSegment, stackSegment, dataSegment, extraSegment};
    seg = segs[k == MAU_REF_FETCH ? 0 : k == MAU_REF_DATA ? 2 : k == MAU_REF_STRDST ? 3 : 1];
    if (reqOverride && (k == MAU_REF_DATA || k == MAU_REF_FRAME))
      seg = segs[reqOverrideSeg];
    n = k == MAU_REF_VECTOR ? 4 : w ? 2 : 1;
    doWr = wr && k != MAU_REF_FETCH && k != MAU_REF_VECTOR;
    exp = 32'h0000_0000;
    for (int i = 0; i < n; i++) begin
      // the byte offset wraps inside its 64K segment before the segment is added
      bo = off + 16'(i);
      ea[i] = k == MAU_REF_VECTOR ? {10'h000, reqIntType, 2'(i)} : {seg, 4'h0} + {4'h0, bo};
      if (doWr)
        bm[ea[i]] = reqWriteData[8*i +: 8];
      exp[8*i +: 8] = bm.exists(ea[i]) ? bm[ea[i]] : ea[i][7:0] ^ ea[i][19:12];
    end
    reqKind = k;
    {reqWord, reqWrite, reqOffset, reqValid} = {w, wr, off, 1'b1};
    wait_ready();
    @(negedge clock);
    reqValid = 1'b0;
    for (int t = 0; t < 400 && respValid !== 1'b1; t++)
      @(negedge clock);
    chk("respValid", 1, respValid);
    if (!doWr)
      chk("respWord", exp, {respSegment, respData});
    chk("busCycles", n, addrQ.size());
    for (int i = 0; i < n && addrQ.size() > 0; i++)
      chk("busAddr", ea[i], addrQ.pop_front());
    addrQ.delete();
  endtask

  initial begin
    {rst, configModeStrap, reqValid, reqWord, reqWrite, reqOverride, lockRequest} = 7'h7f;
    {reqValid, reqOverride, lockRequest, slow} = 4'h0;
    {codeSegment, stackSegment, dataSegment, extraSegment} = 64'h0;
    {reqOffset, reqWriteData, reqIntType} = 40'h0;
    {queueStatusIn, requestGrantLineIn} = 4'h0;
    reqKind = MAU_REF_FETCH;
    reqOverrideSeg = MAU_SEG_CODE;
    void'($urandom(32'h2549_2859));
    repeat (10) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    wait_ready();
    chk("bootAddr", 20'hF_FFF0, addrQ.size() > 0 ? addrQ[0] : 20'h0_0000);
    addrQ.delete();
    // segments kept low so random writes never reach the startup bytes
    {codeSegment, stackSegment, dataSegment, extraSegment} = {$urandom, $urandom}
      & 64'h7FFF_7FFF_7FFF_7FFF;
    for (int i = 0; i < 40; i++) begin
      {reqOverride, slow, reqWriteData} = 18'($urandom);
      reqOverrideSeg = mau_seg_e'($urandom % 4);
      access(mau_ref_e'($urandom % 5), 1'($urandom), 1'($urandom),
        16'($urandom));
    end
    {reqOverride, slow, reqWriteData} = {2'h1, 16'hA55A};
    access(MAU_REF_DATA, 1, 1, 16'hFFFF);
    access(MAU_REF_DATA, 1, 0, 16'hFFFF);
    access(MAU_REF_DATA, 0, 0, 16'h0000);
    {dataSegment, reqIntType, reqWriteData} = {16'h0000, 8'h05, 16'h1234};
    access(MAU_REF_DATA, 1, 1, 16'h0014);
    reqWriteData = 16'hABCD;
    access(MAU_REF_DATA, 1, 1, 16'h0016);
    foreach (cycles_vt[i]) begin
      reqIntType = cycles_vt[i];
      access(MAU_REF_VECTOR, 0, 0, 16'h0000);
    end
    configModeStrap = 1'b0;
    repeat (3) @(negedge clock);
    for (int i = 0; i < 8; i++) begin
      {queueStatusIn, lockRequest} = 3'($urandom);
      @(negedge clock);
      chk("queueStatusOut", queueStatusIn, queueStatusOut);
      chk("busLockOut", lockRequest, busLockOut);
    end
    lockRequest = 1'b0;
    for (int i = 0; i < 6; i++)
      access(mau_ref_e'($urandom % 5), 1'($urandom), 1'($urandom),
        16'($urandom));
    requestGrantLineIn = 2'h1;
    @(negedge clock);
    requestGrantLineIn = 2'h0;
    for (int t = 0; t < 20 && requestGrantLineOut[0] !== 1'b1; t++)
      @(negedge clock);
    chk("grant", 1, requestGrantLineOut[0]);
    chk("grantOe", 2'h1, requestGrantLineOe);
    @(negedge clock);
    chk("heldReady", 0, reqReady);
    requestGrantLineIn = 2'h1;
    @(negedge clock);
    requestGrantLineIn = 2'h0;
    repeat (3) @(negedge clock);
    chk("releasedReady", 1, reqReady);
    configModeStrap = 1'b1;
    codeSegment = 16'hFFFF;
    repeat (3) @(negedge clock);
    access(MAU_REF_FETCH, 1, 0, 16'hFFFF);
    print_verdict();
  end
endmodule
